// ===== bench/dpm_far_model.sv
// dpm_far_model: parity and data wire levels, select decoder and board strap
// assumes the pins of dpm_mux and its one system clock
`timescale 1ns/1ps
module dpm_far_model (
   // clock and board settings
   input wire logic clk,
   input wire logic strap_lvl,
   input wire logic [7:0] io_rd,
   input wire logic [1:0] rd_par,
   // pins from the mux
   input wire logic [11:0] addr,
   input wire logic addr_lo_oe,
   input wire logic par_hi_o,
   input wire logic par_lo_o,
   input wire logic par_oe,
   input wire logic [3:0] row_n,
   input wire logic wr_sel,
   input wire logic cs3_o,
   input wire logic cs3_oe,
   // wire levels back to the mux, and the decoded select
   output logic [7:0] data_i,
   output logic par_hi_i,
   output logic par_lo_i,
   output logic strap_i,
   output logic [4:0] io_sel
);
   logic junk = 1'b0;
   // plain always: the declaration already gives junk its start value
   // ----------------------------------------
   // wire levels
   // ----------------------------------------
   // released parity lines wander, so a stale level never passes
   always @(posedge clk) begin
      junk <= ~junk;
   end
   always_comb begin
      if (par_oe) begin
         {par_hi_i, par_lo_i} = {par_hi_o, par_lo_o};
      end else if (row_n != 4'hf && !wr_sel) begin
         {par_hi_i, par_lo_i} = rd_par;
      end else begin
         {par_hi_i, par_lo_i} = {junk, ~junk};
      end
   end
   // peripheral answers whenever the mux lets go of the low lines
   assign data_i = addr_lo_oe ? addr[7:0] : io_rd;
   // strobe 3 level from the mux while it drives the pin, else the board strap level
   assign strap_i = cs3_oe ? cs3_o : strap_lvl;
   // outside decoder: one of 32 selects
   assign io_sel = {par_hi_i, par_lo_i, addr[10:8]};
endmodule // dpm_far_model

// ===== bench/tb_top.sv
// tb_top: self-checking bench of the shared dram / i-o pin mux
// assumes row 2, column 2 and i-o 3 cycle timing of dpm_pkg
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   miscompares++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top;
   import dpm_pkg::*;
   typedef struct {logic io; logic wr; logic [7:0] data; logic [1:0] par;}
      dpm_exp_t;
   logic clk_sys = 0, reset_n = 0, mem_io = 1, req = 0, wr = 0, strap = 1;
   logic par_hi = 0, par_lo = 0;
   logic [1:0] bank = 0, be = 0, rd_par = 0;
   logic [11:0] row = 0, col = 0, addr;
   logic [4:0] code = 0, io_sel;
   logic [7:0] wdata = 0, io_rd = 0, rdata, data_i;
   logic busy, done, rpar_hi, rpar_lo, lo_oe, pb_hi_o, pb_lo_o, par_oe;
   logic wsel, cs3_o, cs3_oe, mode, processor_reset_out, ph_i, pl_i, strap_i;
   logic [3:0] ras_n, casl_n;
   logic [2:0] cash_n;
   int miscompares = 0, total_checks = 0, cycles = 0;
   logic [31:0] lfsr_st = 32'h3f3b861f;
   dpm_exp_t expq[$];
   dpm_exp_t got_e;
   // ----------------------------------------
   // design and far side
   // ----------------------------------------
   dpm_mux dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .MEM_IO_STATUS(mem_io),
      .CYC_REQ(req), .CYC_WRITE(wr), .CYC_BANK(bank), .CYC_BYTE_EN(be),
      .CYC_ROW(row), .CYC_COL(col), .CYC_PAR_HI(par_hi),
      .CYC_PAR_LO(par_lo), .CYC_CODE(code), .CYC_WDATA(wdata),
      .CYC_BUSY(busy), .CYC_DONE(done), .CYC_RDATA(rdata),
      .CYC_RPAR_HI(rpar_hi), .CYC_RPAR_LO(rpar_lo), .MEM_ADDR_O(addr),
      .MEM_ADDR_LO_OE(lo_oe), .PERIPH_DATA_I(data_i),
      .UPPER_BYTE_PARITY_O(pb_hi_o), .LOWER_BYTE_PARITY_O(pb_lo_o),
      .PARITY_OE(par_oe), .UPPER_BYTE_PARITY_I(ph_i),
      .LOWER_BYTE_PARITY_I(pl_i), .ROW_STROBE_N(ras_n),
      .UPPER_COL_STROBE_N(cash_n), .LOWER_COL_STROBE_N(casl_n),
      .DRAM_WRITE_SELECT(wsel), .UPPER_COL_STROBE3_O(cs3_o),
      .UPPER_COL_STROBE3_OE(cs3_oe), .COL_STROBE_STRAP_I(strap_i),
      .COL_STROBE_OUT_MODE(mode), .PROCESSOR_RESET_OUT(processor_reset_out));
   dpm_far_model far (.clk(clk_sys), .strap_lvl(strap), .io_rd(io_rd),
      .rd_par(rd_par), .addr(addr), .addr_lo_oe(lo_oe), .par_hi_o(pb_hi_o),
      .par_lo_o(pb_lo_o), .par_oe(par_oe), .row_n(ras_n), .wr_sel(wsel),
      .cs3_o(cs3_o), .cs3_oe(cs3_oe), .data_i(data_i), .par_hi_i(ph_i),
      .par_lo_i(pl_i), .strap_i(strap_i), .io_sel(io_sel));
   // ----------------------------------------
   // clock, timeout, monitors
   // ----------------------------------------
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         final_report();
      end
   end
   always @(processor_reset_out) begin
      if ($time > 0) `CHK("processor_reset_out_sync", 1'b1, clk_sys)
   end
   // results are matched oldest first, one per done pulse
   always @(negedge clk_sys) begin
      if (done === 1'b1) begin
         got_e = expq.pop_front();
         if (got_e.io && !got_e.wr) `CHK("io_rdata", got_e.data, rdata)
         else if (!got_e.io && !got_e.wr)
            `CHK("rpar", got_e.par, {rpar_hi, rpar_lo})
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic do_reset(input logic s);
      reset_n = 0;
      strap = s;
      repeat (10) @(negedge clk_sys);
      `CHK("strap_float", 1'b0, cs3_oe)
      `CHK("processor_reset_out_on", 1'b1, processor_reset_out)
      reset_n = 1;
      repeat (2) @(negedge clk_sys);
      `CHK("strap_mode", s, mode)
      `CHK("cs3_drive", s, cs3_oe)
      strap = 1'b1;
      repeat (77) @(negedge clk_sys);
      `CHK("processor_reset_out_held", 1'b1, processor_reset_out)
      repeat (10) @(negedge clk_sys);
      `CHK("processor_reset_out_off", 1'b0, processor_reset_out)
   endtask
   // one access; flip moves the status line in mid-access
   task automatic cyc(input logic io, input logic w, input logic flip);
      logic [3:0] hi_m;
      int n;
      lfsr_st = lfsr(lfsr_st);
      bank = lfsr_st[1:0];
      be = (lfsr_st[3:2] == 2'h0) ? 2'h3 : lfsr_st[3:2];
      {row, col, par_hi, par_lo} = lfsr_st[29:4];
      lfsr_st = lfsr(lfsr_st);
      {code, wdata, io_rd, rd_par} = lfsr_st[22:0];
      hi_m = ~({3'h0, be[1]} << bank);
      mem_io = !io;
      repeat (3) @(negedge clk_sys);
      expq.push_back('{io, w, io_rd, rd_par});
      wr = w;
      req = 1;
      @(negedge clk_sys);
      req = 0;
      @(negedge clk_sys);
      if (io) begin
         `CHK("io_strobes", 11'h7ff, {ras_n, casl_n, cash_n})
         `CHK("io_sel", code, io_sel)
         `CHK("io_lo_oe", w, lo_oe)
         `CHK("io_wsel", 1'b0, wsel)
         `CHK("io_a11", 1'b0, addr[11])
         if (w) `CHK("io_wdata", wdata, addr[7:0])
      end else begin
         `CHK("row_addr", row, addr)
         `CHK("row_strobe", ~(4'h1 << bank), ras_n)
         `CHK("wr_sel", w, wsel)
         if (flip) mem_io = 1'b0;
         repeat (2) @(negedge clk_sys);
         `CHK("col_addr", col, addr)
         `CHK("col_lo", ~({3'h0, be[0]} << bank), casl_n)
         `CHK("col_hi", hi_m[2:0], cash_n)
         `CHK("col_hi3", hi_m[3], cs3_o)
         `CHK("par_oe", w, par_oe)
         if (w) `CHK("par_out", {par_hi, par_lo}, {pb_hi_o, pb_lo_o})
      end
      n = 0;
      while (busy === 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK("busy_ends", 1'b0, busy)
      @(negedge clk_sys);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      do_reset(1'b1);
      for (int i = 0; i < 8; i++) begin
         cyc(1'b0, 1'b1, 1'b0);
         cyc(1'b0, 1'b0, i == 3);
         cyc(1'b1, i[0], 1'b0);
      end
      do_reset(1'b0);
      cyc(1'b0, 1'b1, 1'b0);
      `CHK("cs3_input", 1'b0, cs3_oe)
      final_report();
   end
endmodule // tb_top

// ===== pkg/dpm_pkg.sv
// dpm_pkg: constants and types of the shared dram / i-o pin mux
// assumes a single 100 MHz system clock
package dpm_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned ROW_TIME_NS = 20;
   localparam int unsigned COL_TIME_NS = 20;
   localparam int unsigned IO_TIME_NS = 30;
   // least times, rounded up to whole cycles
   localparam int unsigned ROW_CYCLES =
      (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned COL_CYCLES =
      (COL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned IO_CYCLES =
      (IO_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PROC_RESET_HOLD = 84;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CODE_W = 5;
   localparam int unsigned CNT_W = 7;
   localparam int unsigned SYNC_W = 12;
   // ----------------------------------------
   // cycle sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      S_IDLE,
      S_ROW,
      S_COL,
      S_IO,
      S_END
   } dpm_state_t;
endpackage

// ===== pkg/dpm_samp_if.sv
// dpm_samp_if: pin levels after the two-flop synchroniser
// driven by dpm_sync, read by the mux core
`timescale 1ns/1ps
interface dpm_samp_if;
   logic mem_io;
   logic strap;
   logic par_hi;
   logic par_lo;
   logic [7:0] data;
   modport drv (output mem_io, strap, par_hi, par_lo, data);
   modport use_side (input mem_io, strap, par_hi, par_lo, data);
endinterface

// ===== src/dpm_mux.sv
// dpm_mux: shared dram address / parity and i-o select / data pins
// assumes cycle requests from same-clock logic; pins synchronised here
//
// What this block does
// - Dram: upper parity pin is driven on writes and sampled on reads.
// - Dram: lower parity pin is driven on writes and sampled on reads.
// - I-o: upper and lower parity pins drive select code bits 4 and 3.
// - Dram: the twelve address pins carry row, then column address.
// - I-o: pins 10 to 8 drive code bits 2 to 0, decoded to one of 32.
// - I-o: the eight low address pins form a two-way peripheral data bus.
// - While reset is low the strobe 3 pin floats and is read as a strap.
// - A strap held high through reset release makes strobe 3 an output.
// - The processor reset output changes only on clock edges.
`timescale 1ns/1ps
module dpm_mux
   import dpm_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RESET_N,
   // cycle request from the controller
   input wire logic MEM_IO_STATUS,
   input wire logic CYC_REQ,
   input wire logic CYC_WRITE,
   input wire logic [1:0] CYC_BANK,
   input wire logic [1:0] CYC_BYTE_EN,
   input wire logic [ADDR_W-1:0] CYC_ROW,
   input wire logic [ADDR_W-1:0] CYC_COL,
   input wire logic CYC_PAR_HI,
   input wire logic CYC_PAR_LO,
   input wire logic [CODE_W-1:0] CYC_CODE,
   input wire logic [DATA_W-1:0] CYC_WDATA,
   // cycle answer
   output logic CYC_BUSY,
   output logic CYC_DONE,
   output logic [DATA_W-1:0] CYC_RDATA,
   output logic CYC_RPAR_HI,
   output logic CYC_RPAR_LO,
   // shared address / data pins
   output logic [ADDR_W-1:0] MEM_ADDR_O,
   output logic MEM_ADDR_LO_OE,
   input wire logic [DATA_W-1:0] PERIPH_DATA_I,
   // parity / select code pins
   output logic UPPER_BYTE_PARITY_O,
   output logic LOWER_BYTE_PARITY_O,
   output logic PARITY_OE,
   input wire logic UPPER_BYTE_PARITY_I,
   input wire logic LOWER_BYTE_PARITY_I,
   // dram strobes, active low, and write select, high on writes
   output logic [3:0] ROW_STROBE_N,
   output logic [2:0] UPPER_COL_STROBE_N,
   output logic [3:0] LOWER_COL_STROBE_N,
   output logic DRAM_WRITE_SELECT,
   // column strobe 3 pin with strap
   output logic UPPER_COL_STROBE3_O,
   output logic UPPER_COL_STROBE3_OE,
   input wire logic COL_STROBE_STRAP_I,
   output logic COL_STROBE_OUT_MODE,
   // processor reset
   output logic PROCESSOR_RESET_OUT
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   dpm_samp_if s ();

   dpm_sync u_sync (
      .clk(CLK_SYS),
      .mem_io_pin(MEM_IO_STATUS),
      .strap_pin(COL_STROBE_STRAP_I),
      .par_hi_pin(UPPER_BYTE_PARITY_I),
      .par_lo_pin(LOWER_BYTE_PARITY_I),
      .data_pin(PERIPH_DATA_I),
      .s(s)
   );

   // ----------------------------------------
   // decoders
   // ----------------------------------------
   function automatic logic [3:0] strobe_dec(input logic [1:0] bank,
                                             input logic en);
      strobe_dec = ~((4'h1 << bank) & {4{en}});
   endfunction

   // ----------------------------------------
   // cycle sequencer
   // ----------------------------------------
   dpm_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic io_role, next_io_role;
   logic lat_wr, next_lat_wr;
   logic [1:0] lat_bank, next_lat_bank;
   logic [1:0] lat_be, next_lat_be;
   logic [ADDR_W-1:0] lat_col, next_lat_col;
   logic [1:0] lat_par, next_lat_par;
   logic [3:0] cash_n, next_cash_n;
   logic next_busy, next_done, next_rphi, next_rplo, next_wsel;
   logic [DATA_W-1:0] next_rdata;
   logic [ADDR_W-1:0] next_addr;
   logic next_lo_oe, next_par_oe, next_uphi, next_uplo;
   logic [3:0] next_ras_n, next_casl_n;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_io_role = io_role;
      next_lat_wr = lat_wr;
      next_lat_bank = lat_bank;
      next_lat_be = lat_be;
      next_lat_col = lat_col;
      next_lat_par = lat_par;
      next_busy = CYC_BUSY;
      next_done = 1'b0;
      next_rdata = CYC_RDATA;
      next_rphi = CYC_RPAR_HI;
      next_rplo = CYC_RPAR_LO;
      next_addr = MEM_ADDR_O;
      next_lo_oe = MEM_ADDR_LO_OE;
      next_par_oe = PARITY_OE;
      next_uphi = UPPER_BYTE_PARITY_O;
      next_uplo = LOWER_BYTE_PARITY_O;
      next_wsel = DRAM_WRITE_SELECT;
      next_ras_n = 4'hf;
      next_cash_n = 4'hf;
      next_casl_n = 4'hf;
      unique case (state)
         S_IDLE: begin
            // role taken only here, so it never flips mid access
            if (CYC_REQ) begin
               next_busy = 1'b1;
               next_lat_wr = CYC_WRITE;
               next_lat_bank = CYC_BANK;
               next_lat_be = CYC_BYTE_EN;
               next_lat_col = CYC_COL;
               next_lat_par = {CYC_PAR_HI, CYC_PAR_LO};
               next_io_role = ~s.mem_io;
               if (s.mem_io) begin
                  next_state = S_ROW;
                  next_cnt = CNT_W'(ROW_CYCLES - 1);
                  next_addr = CYC_ROW;
                  next_lo_oe = 1'b1;
                  next_par_oe = 1'b0;
                  next_wsel = CYC_WRITE;
                  next_ras_n = strobe_dec(CYC_BANK, 1'b1);
               end else begin
                  next_state = S_IO;
                  next_cnt = CNT_W'(IO_CYCLES - 1);
                  next_addr = {1'b0, CYC_CODE[2:0], CYC_WDATA};
                  next_lo_oe = CYC_WRITE;
                  next_par_oe = 1'b1;
                  next_uphi = CYC_CODE[4];
                  next_uplo = CYC_CODE[3];
               end
            end
         end
         S_ROW: begin
            next_ras_n = strobe_dec(lat_bank, 1'b1);
            next_cnt = cnt - 1'b1;
            if (cnt == '0) begin
               next_state = S_COL;
               next_cnt = CNT_W'(COL_CYCLES - 1);
               next_addr = lat_col;
               next_cash_n = strobe_dec(lat_bank, lat_be[1]);
               next_casl_n = strobe_dec(lat_bank, lat_be[0]);
               next_par_oe = lat_wr;
               next_uphi = lat_par[1];
               next_uplo = lat_par[0];
            end
         end
         S_COL: begin
            next_ras_n = ROW_STROBE_N;
            next_cash_n = cash_n;
            next_casl_n = LOWER_COL_STROBE_N;
            next_cnt = cnt - 1'b1;
            if (cnt == '0) begin
               next_state = S_END;
               next_done = 1'b1;
               if (!lat_wr) begin
                  next_rphi = s.par_hi;
                  next_rplo = s.par_lo;
               end
            end
         end
         S_IO: begin
            // strobes stay at their idle default here
            next_cnt = cnt - 1'b1;
            if (cnt == '0) begin
               next_state = S_END;
               next_done = 1'b1;
               if (!lat_wr) begin
                  next_rdata = s.data;
               end
            end
         end
         S_END: begin
            next_state = S_IDLE;
            next_busy = 1'b0;
            next_lo_oe = 1'b1;
            next_par_oe = 1'b0;
            next_wsel = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         state <= S_IDLE;
         cnt <= '0;
         io_role <= 1'b0;
         lat_wr <= 1'b0;
         lat_bank <= 2'h0;
         lat_be <= 2'h0;
         lat_col <= '0;
         lat_par <= 2'h0;
         CYC_BUSY <= 1'b0;
         CYC_DONE <= 1'b0;
         CYC_RDATA <= '0;
         CYC_RPAR_HI <= 1'b0;
         CYC_RPAR_LO <= 1'b0;
         MEM_ADDR_O <= '0;
         MEM_ADDR_LO_OE <= 1'b1;
         PARITY_OE <= 1'b0;
         UPPER_BYTE_PARITY_O <= 1'b0;
         LOWER_BYTE_PARITY_O <= 1'b0;
         DRAM_WRITE_SELECT <= 1'b0;
         ROW_STROBE_N <= 4'hf;
         cash_n <= 4'hf;
         LOWER_COL_STROBE_N <= 4'hf;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         io_role <= next_io_role;
         lat_wr <= next_lat_wr;
         lat_bank <= next_lat_bank;
         lat_be <= next_lat_be;
         lat_col <= next_lat_col;
         lat_par <= next_lat_par;
         CYC_BUSY <= next_busy;
         CYC_DONE <= next_done;
         CYC_RDATA <= next_rdata;
         CYC_RPAR_HI <= next_rphi;
         CYC_RPAR_LO <= next_rplo;
         MEM_ADDR_O <= next_addr;
         MEM_ADDR_LO_OE <= next_lo_oe;
         PARITY_OE <= next_par_oe;
         UPPER_BYTE_PARITY_O <= next_uphi;
         LOWER_BYTE_PARITY_O <= next_uplo;
         DRAM_WRITE_SELECT <= next_wsel;
         ROW_STROBE_N <= next_ras_n;
         cash_n <= next_cash_n;
         LOWER_COL_STROBE_N <= next_casl_n;
      end
   end

   assign UPPER_COL_STROBE_N = cash_n[2:0];

   // ----------------------------------------
   // strap, column strobe 3 and processor reset
   // ----------------------------------------
   logic next_mode, next_cs3_oe, next_cs3, next_prst;
   logic [CNT_W-1:0] prst_cnt, next_prst_cnt;

   // strap follows the pin while in reset, frozen at release
   always_comb begin
      next_mode = RESET_N ? COL_STROBE_OUT_MODE : s.strap;
      next_cs3_oe = RESET_N & COL_STROBE_OUT_MODE;
      // same edge as the other column strobes, no extra cycle of lag
      next_cs3 = next_cash_n[3];
      next_prst_cnt = (prst_cnt != '0) ? prst_cnt - 1'b1 : prst_cnt;
      next_prst = (prst_cnt != '0);
   end

   // mode has no reset value of its own: it is loaded during reset
   always_ff @(posedge CLK_SYS) begin
      COL_STROBE_OUT_MODE <= next_mode;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         UPPER_COL_STROBE3_OE <= 1'b0;
         UPPER_COL_STROBE3_O <= 1'b1;
         prst_cnt <= CNT_W'(PROC_RESET_HOLD);
         PROCESSOR_RESET_OUT <= 1'b1;
      end else begin
         UPPER_COL_STROBE3_OE <= next_cs3_oe;
         UPPER_COL_STROBE3_O <= next_cs3;
         prst_cnt <= next_prst_cnt;
         PROCESSOR_RESET_OUT <= next_prst;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);

   upar_dram_a: assert property (PARITY_OE && !io_role |->
      UPPER_BYTE_PARITY_O == lat_par[1] && lat_wr)
      else $error("upper parity wrong in dram write");
   lpar_dram_a: assert property (state == S_COL && !lat_wr |->
      !PARITY_OE && LOWER_BYTE_PARITY_O == lat_par[0] || !PARITY_OE)
      else $error("lower parity driven on dram read");
   code_hi_a: assert property (state == S_IO |-> PARITY_OE &&
      {UPPER_BYTE_PARITY_O, LOWER_BYTE_PARITY_O} ==
      $past(CYC_CODE[4:3], 1) || $past(state) == S_IO)
      else $error("select code bits four and three wrong");
   row_col_a: assert property ($rose(state == S_ROW) |->
      MEM_ADDR_O == $past(CYC_ROW) ##2 MEM_ADDR_O == lat_col)
      else $error("row then column order broken");
   code_lo_a: assert property ($rose(state == S_IO) |->
      MEM_ADDR_O[10:8] == $past(CYC_CODE[2:0]))
      else $error("select code bits two to zero wrong");
   io_data_a: assert property (state == S_IO |->
      MEM_ADDR_LO_OE == lat_wr)
      else $error("peripheral data direction wrong");
   strap_z_a: assert property (disable iff (1'b0)
      $past(!RESET_N) |-> !UPPER_COL_STROBE3_OE)
      else $error("strap pin driven in reset");
   strap_mode_a: assert property (UPPER_COL_STROBE3_OE |->
      COL_STROBE_OUT_MODE)
      else $error("strobe 3 driven in input mode");
   proc_rst_a: assert property (disable iff (1'b0)
      $rose(RESET_N) |-> PROCESSOR_RESET_OUT [*8])
      else $error("processor reset released too early");
   io_quiet_a: assert property (io_role && state != S_IDLE |->
      &ROW_STROBE_N && &cash_n && &LOWER_COL_STROBE_N)
      else $error("strobe active during i-o cycle");
   role_hold_a: assert property (state != S_IDLE &&
      $past(state) != S_IDLE |-> $stable(io_role))
      else $error("role changed mid access");

   dram_wr_c: cover property (state == S_COL && lat_wr);
   dram_rd_c: cover property (state == S_COL && !lat_wr ##1 CYC_DONE);
   io_rd_c: cover property (state == S_IO && !lat_wr ##[1:4] CYC_DONE);
   io_wr_c: cover property (state == S_IO && lat_wr);
endmodule // dpm_mux

// ===== src/dpm_sync.sv
// dpm_sync: two-flop synchronisers for every pin input of the mux
// assumes pins are asynchronous to the system clock
`timescale 1ns/1ps
module dpm_sync
   import dpm_pkg::*;
(
   // clock
   input wire logic clk,
   // raw pins
   input wire logic mem_io_pin,
   input wire logic strap_pin,
   input wire logic par_hi_pin,
   input wire logic par_lo_pin,
   input wire logic [7:0] data_pin,
   // synchronised levels
   dpm_samp_if.drv s
);
   logic [SYNC_W-1:0] meta;
   logic [SYNC_W-1:0] stable;
   logic [SYNC_W-1:0] next_meta;
   logic [SYNC_W-1:0] next_stable;

   // first stage is read by the second stage only
   always_comb begin
      next_meta = {mem_io_pin, strap_pin, par_hi_pin, par_lo_pin, data_pin};
      next_stable = meta;
   end

   always_ff @(posedge clk) begin
      meta <= next_meta;
      stable <= next_stable;
   end

   assign s.mem_io = stable[11];
   assign s.strap = stable[10];
   assign s.par_hi = stable[9];
   assign s.par_lo = stable[8];
   assign s.data = stable[7:0];
endmodule // dpm_sync
